/* verilog/tmc_pkg.sv */
package tmc_pkg;

    // ****************************************
    // register offsets, one byte register each
    // ****************************************
    localparam logic [3:0] ADDR_TSC  = 4'h0;
    localparam logic [3:0] ADDR_CNTH = 4'h1;
    localparam logic [3:0] ADDR_CNTL = 4'h2;
    localparam logic [3:0] ADDR_MODH = 4'h3;
    localparam logic [3:0] ADDR_MODL = 4'h4;
    localparam logic [3:0] ADDR_CSC  = 4'h5;
    localparam logic [3:0] ADDR_CVH  = 4'h6;
    localparam logic [3:0] ADDR_CVL  = 4'h7;

    // ****************************************
    // field positions
    // ****************************************
    localparam int TSC_FLAG    = 7;
    localparam int TSC_IE      = 6;
    localparam int TSC_CENTER_PWM_SELECT   = 5;
    localparam int TSC_CLKS_LO = 3;
    localparam int TSC_PS_LO   = 0;
    localparam int CSC_FLAG    = 7;
    localparam int CSC_IE      = 6;
    localparam int CSC_MODE_LO = 4;
    localparam int CSC_ELS_LO  = 2;

    // ****************************************
    // encodings and reset values
    // ****************************************
    localparam logic [1:0] CLKS_OFF   = 2'h0;
    localparam logic [1:0] CLKS_BUS   = 2'h1;
    localparam logic [1:0] CLKS_FIXED = 2'h2;
    localparam logic [1:0] CLKS_EXT   = 2'h3;
    localparam logic [1:0] ELS_OFF    = 2'h0;
    localparam logic [1:0] ELS_RISE   = 2'h1;
    localparam logic [1:0] ELS_FALL   = 2'h2;
    localparam logic [1:0] ELS_BOTH   = 2'h3;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hffff;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    typedef enum logic [1:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EPWM,
        MODE_CPWM
    } tmc_mode_t;

endpackage

/* verilog/tmc_timer.sv */
`timescale 1ns/1ps
module tmc_timer (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       bdm_active,
    input  wire logic       stop_mode,
    input  wire logic       fixed_clk_tick,
    input  wire logic       ext_clk_pin,
    input  wire logic       chan_pin_in,
    output logic            chan_pin_out,
    output logic            chan_pin_oe,
    output logic            tof_irq,
    output logic            chan_irq
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [15:0] cnt;
        logic        down;
        logic [6:0]  pre;
        logic        counter_overflow_flag;
        logic        tof_armed;
        logic        overflow_interrupt_enable;
        logic        center_pwm_select;
        logic [1:0]  clks;
        logic [2:0]  ps;
        logic [15:0] modv;
        logic [15:0] mod_buf;
        logic        mod_hw;
        logic        mod_lw;
        logic [15:0] cnt_buf;
        logic        cnt_lat;
        logic        cnt_lat_hi;
        logic        chf;
        logic        chf_armed;
        logic        chie;
        logic [1:0]  ms;
        logic [1:0]  els;
        logic [15:0] cv;
        logic [15:0] cv_buf;
        logic        cv_hw;
        logic        cv_lw;
        logic [15:0] cap_buf;
        logic        cap_lat;
        logic        cap_lat_hi;
        logic [2:0]  pin_sync;
        logic [2:0]  ext_sync;
        logic        pin_out;
        logic        pin_oe;
        logic [7:0]  rdata;
        logic        tof_irq;
        logic        chan_irq;
    } tmc_state_t;

    tmc_state_t        st_ff;
    tmc_state_t        nxt_st;
    tmc_pkg::tmc_mode_t mode;
    logic              src_tick;
    logic              pre_last;
    logic              tick;
    logic              ovf;
    logic              match;
    logic              edge_ev;
    logic              ch_evt;
    logic              is_hi;
    logic              cv_full;
    logic [15:0]       tc;

    // byte lane of a 16-bit word
    function automatic logic [7:0] byte_sel(input logic hi, input logic [15:0] w);
        byte_sel = hi ? w[15:8] : w[7:0];
    endfunction

    // prescale terminal value, divide by 2**sel
    function automatic logic [6:0] div_mask(input logic [2:0] sel);
        div_mask = 7'((8'h01 << sel) - 8'h01);
    endfunction

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        // pins go through three flops; edges look at the second and third only
        nxt_st.pin_sync = {st_ff.pin_sync[1:0], chan_pin_in};
        nxt_st.ext_sync = {st_ff.ext_sync[1:0], ext_clk_pin};
        // channel mode, center pwm overrides the channel bits
        if (st_ff.center_pwm_select) begin
            mode = tmc_pkg::MODE_CPWM;
        end else if (st_ff.ms[1]) begin
            mode = tmc_pkg::MODE_EPWM;
        end else if (st_ff.ms[0]) begin
            mode = tmc_pkg::MODE_COMPARE;
        end else begin
            mode = tmc_pkg::MODE_CAPTURE;
        end
        // clock source; external edges need the quarter-rate limit
        unique case (st_ff.clks)
            tmc_pkg::CLKS_OFF:   src_tick = 1'b0;
            tmc_pkg::CLKS_BUS:   src_tick = 1'b1;
            tmc_pkg::CLKS_FIXED: src_tick = fixed_clk_tick;
            tmc_pkg::CLKS_EXT:   src_tick = st_ff.ext_sync[1] & ~st_ff.ext_sync[2];
        endcase
        pre_last = st_ff.pre == div_mask(st_ff.ps);
        tick = src_tick && !bdm_active && !stop_mode && pre_last;
        if (src_tick && !bdm_active && !stop_mode) begin
            nxt_st.pre = pre_last ? 7'h00 : st_ff.pre + 7'h01;
        end
        // counter; a zero modulus means free running
        tc = (st_ff.modv == tmc_pkg::CNT_ZERO) ? tmc_pkg::CNT_MAX : st_ff.modv;
        ovf = 1'b0;
        if (tick) begin
            if (!st_ff.center_pwm_select) begin
                nxt_st.down = 1'b0;
                if (st_ff.cnt == tc) begin
                    nxt_st.cnt = tmc_pkg::CNT_ZERO;
                    ovf = 1'b1;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 16'h0001;
                end
            end else if (!st_ff.down) begin
                if (st_ff.cnt == tc) begin
                    nxt_st.down = 1'b1;
                    nxt_st.cnt = st_ff.cnt - 16'h0001;
                    ovf = 1'b1;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 16'h0001;
                end
            end else if (st_ff.cnt == tmc_pkg::CNT_ZERO) begin
                nxt_st.down = 1'b0;
                nxt_st.cnt = 16'h0001;
            end else begin
                nxt_st.cnt = st_ff.cnt - 16'h0001;
            end
        end
        // channel behaviour
        match = tick && (st_ff.cnt == st_ff.cv);
        unique case (st_ff.els)
            tmc_pkg::ELS_OFF:  edge_ev = 1'b0;
            tmc_pkg::ELS_RISE: edge_ev = st_ff.pin_sync[1] & ~st_ff.pin_sync[2];
            tmc_pkg::ELS_FALL: edge_ev = ~st_ff.pin_sync[1] & st_ff.pin_sync[2];
            tmc_pkg::ELS_BOTH: edge_ev = st_ff.pin_sync[1] ^ st_ff.pin_sync[2];
        endcase
        ch_evt = 1'b0;
        unique case (mode)
            tmc_pkg::MODE_CAPTURE: begin
                if (edge_ev) begin
                    nxt_st.cv = st_ff.cnt;
                    ch_evt = 1'b1;
                end
            end
            tmc_pkg::MODE_COMPARE: begin
                if (match) begin
                    ch_evt = 1'b1;
                    unique case (st_ff.els)
                        tmc_pkg::ELS_OFF:  nxt_st.pin_out = st_ff.pin_out;
                        tmc_pkg::ELS_RISE: nxt_st.pin_out = ~st_ff.pin_out;
                        tmc_pkg::ELS_FALL: nxt_st.pin_out = 1'b0;
                        tmc_pkg::ELS_BOTH: nxt_st.pin_out = 1'b1;
                    endcase
                end
            end
            tmc_pkg::MODE_EPWM: begin
                // level from count keeps 0% and 100% exact
                ch_evt = match;
                nxt_st.pin_out = (nxt_st.cnt < st_ff.cv) ^ st_ff.els[0];
            end
            tmc_pkg::MODE_CPWM: begin
                // negative or zero value reads as 0% duty; the down-count match
                // sits inside the pulse so its width is twice the value
                ch_evt = match;
                nxt_st.pin_out = (!st_ff.cv[15] && st_ff.cv != tmc_pkg::CNT_ZERO
                                  && (nxt_st.cnt < st_ff.cv
                                      || (nxt_st.down && nxt_st.cnt == st_ff.cv)))
                                 ^ st_ff.els[0];
            end
        endcase
        nxt_st.pin_oe = (st_ff.els != tmc_pkg::ELS_OFF)
                        && (mode != tmc_pkg::MODE_CAPTURE);
        // coherent value transfer; pwm waits for a period boundary
        cv_full = st_ff.cv_hw && st_ff.cv_lw;
        if (cv_full && (mode == tmc_pkg::MODE_COMPARE || mode == tmc_pkg::MODE_CAPTURE
                || (mode == tmc_pkg::MODE_EPWM && st_ff.cnt == tmc_pkg::CNT_ZERO)
                || (mode == tmc_pkg::MODE_CPWM && ovf))) begin
            nxt_st.cv = st_ff.cv_buf;
            nxt_st.cv_hw = 1'b0;
            nxt_st.cv_lw = 1'b0;
        end
        if (st_ff.mod_hw && st_ff.mod_lw) begin
            nxt_st.modv = st_ff.mod_buf;
            nxt_st.mod_hw = 1'b0;
            nxt_st.mod_lw = 1'b0;
        end
        // register writes
        is_hi = (reg_addr == tmc_pkg::ADDR_CNTH) || (reg_addr == tmc_pkg::ADDR_MODH)
                || (reg_addr == tmc_pkg::ADDR_CVH);
        if (reg_wr) begin
            unique case (reg_addr)
                tmc_pkg::ADDR_TSC: begin
                    if (!reg_wdata[tmc_pkg::TSC_FLAG] && st_ff.tof_armed) begin
                        nxt_st.counter_overflow_flag = 1'b0;
                    end
                    nxt_st.tof_armed = 1'b0;
                    nxt_st.overflow_interrupt_enable = reg_wdata[tmc_pkg::TSC_IE];
                    nxt_st.center_pwm_select = reg_wdata[tmc_pkg::TSC_CENTER_PWM_SELECT];
                    nxt_st.clks = reg_wdata[tmc_pkg::TSC_CLKS_LO +: 2];
                    nxt_st.ps = reg_wdata[tmc_pkg::TSC_PS_LO +: 3];
                    nxt_st.mod_hw = 1'b0;
                    nxt_st.mod_lw = 1'b0;
                end
                tmc_pkg::ADDR_CNTH, tmc_pkg::ADDR_CNTL: begin
                    nxt_st.cnt = tmc_pkg::CNT_ZERO;
                    nxt_st.down = 1'b0;
                    nxt_st.pre = 7'h00;
                    nxt_st.cnt_lat = 1'b0;
                end
                tmc_pkg::ADDR_MODH, tmc_pkg::ADDR_MODL: begin
                    if (is_hi) begin
                        nxt_st.mod_buf[15:8] = reg_wdata;
                        nxt_st.mod_hw = 1'b1;
                    end else begin
                        nxt_st.mod_buf[7:0] = reg_wdata;
                        nxt_st.mod_lw = 1'b1;
                    end
                end
                tmc_pkg::ADDR_CSC: begin
                    if (!reg_wdata[tmc_pkg::CSC_FLAG] && st_ff.chf_armed) begin
                        nxt_st.chf = 1'b0;
                    end
                    nxt_st.chf_armed = 1'b0;
                    nxt_st.chie = reg_wdata[tmc_pkg::CSC_IE];
                    nxt_st.ms = reg_wdata[tmc_pkg::CSC_MODE_LO +: 2];
                    nxt_st.els = reg_wdata[tmc_pkg::CSC_ELS_LO +: 2];
                    nxt_st.cv_hw = 1'b0;
                    nxt_st.cv_lw = 1'b0;
                    nxt_st.cap_lat = 1'b0;
                end
                tmc_pkg::ADDR_CVH, tmc_pkg::ADDR_CVL: begin
                    if (is_hi) begin
                        nxt_st.cv_buf[15:8] = reg_wdata;
                        nxt_st.cv_hw = 1'b1;
                    end else begin
                        nxt_st.cv_buf[7:0] = reg_wdata;
                        nxt_st.cv_lw = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // hardware sets come last so an event beats a clear in the same cycle
        if (ovf) begin
            nxt_st.counter_overflow_flag = 1'b1;
            nxt_st.tof_armed = 1'b0;
        end
        if (ch_evt) begin
            nxt_st.chf = 1'b1;
            nxt_st.chf_armed = 1'b0;
        end
        // register reads; data stands one cycle only
        nxt_st.rdata = tmc_pkg::BYTE_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                tmc_pkg::ADDR_TSC: begin
                    nxt_st.rdata = {st_ff.counter_overflow_flag, st_ff.overflow_interrupt_enable, st_ff.center_pwm_select, st_ff.clks, st_ff.ps};
                    nxt_st.tof_armed = (st_ff.counter_overflow_flag || st_ff.tof_armed) && !ovf;
                end
                tmc_pkg::ADDR_CNTH, tmc_pkg::ADDR_CNTL: begin
                    if (!st_ff.cnt_lat) begin
                        nxt_st.rdata = byte_sel(is_hi, st_ff.cnt);
                        nxt_st.cnt_buf = st_ff.cnt;
                        nxt_st.cnt_lat = 1'b1;
                        nxt_st.cnt_lat_hi = is_hi;
                    end else begin
                        nxt_st.rdata = byte_sel(is_hi, st_ff.cnt_buf);
                        nxt_st.cnt_lat = (is_hi == st_ff.cnt_lat_hi);
                    end
                end
                tmc_pkg::ADDR_MODH, tmc_pkg::ADDR_MODL: begin
                    nxt_st.rdata = byte_sel(is_hi, st_ff.modv);
                end
                tmc_pkg::ADDR_CSC: begin
                    nxt_st.rdata = {st_ff.chf, st_ff.chie, st_ff.ms, st_ff.els, 2'h0};
                    nxt_st.chf_armed = (st_ff.chf || st_ff.chf_armed) && !ch_evt;
                end
                tmc_pkg::ADDR_CVH, tmc_pkg::ADDR_CVL: begin
                    if (mode != tmc_pkg::MODE_CAPTURE) begin
                        nxt_st.rdata = byte_sel(is_hi, st_ff.cv);
                    end else if (!st_ff.cap_lat) begin
                        nxt_st.rdata = byte_sel(is_hi, st_ff.cv);
                        nxt_st.cap_buf = st_ff.cv;
                        nxt_st.cap_lat = 1'b1;
                        nxt_st.cap_lat_hi = is_hi;
                    end else begin
                        nxt_st.rdata = byte_sel(is_hi, st_ff.cap_buf);
                        nxt_st.cap_lat = (is_hi == st_ff.cap_lat_hi);
                    end
                end
                default: begin
                end
            endcase
        end
        // interrupt levels follow flag and enable
        nxt_st.tof_irq = nxt_st.counter_overflow_flag && nxt_st.overflow_interrupt_enable;
        nxt_st.chan_irq = nxt_st.chf && nxt_st.chie;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata    = st_ff.rdata;
    assign chan_pin_out = st_ff.pin_out;
    assign chan_pin_oe  = st_ff.pin_oe;
    assign tof_irq      = st_ff.tof_irq;
    assign chan_irq     = st_ff.chan_irq;

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_disconnect;
        st_ff.els == tmc_pkg::ELS_OFF |=> !chan_pin_oe;
    endproperty
    a_disconnect: assert property (p_disconnect) else $error("pin driven while disconnected");

    property p_capture;
        mode == tmc_pkg::MODE_CAPTURE && edge_ev |=> st_ff.chf && st_ff.cv == $past(st_ff.cnt);
    endproperty
    a_capture: assert property (p_capture) else $error("capture edge lost");

    property p_set_on_compare;
        mode == tmc_pkg::MODE_COMPARE && match && st_ff.els == tmc_pkg::ELS_BOTH |=> chan_pin_out;
    endproperty
    a_set_on_compare: assert property (p_set_on_compare) else $error("compare set missing");

    property p_csc_discard;
        reg_wr && reg_addr == tmc_pkg::ADDR_CSC |=> !st_ff.cv_hw && !st_ff.cv_lw && !st_ff.cap_lat;
    endproperty
    a_csc_discard: assert property (p_csc_discard) else $error("half access survived");

    property p_clock_off;
        st_ff.clks == tmc_pkg::CLKS_OFF && !reg_wr |=> st_ff.cnt == $past(st_ff.cnt);
    endproperty
    a_clock_off: assert property (p_clock_off) else $error("counter moved with no clock");

    property p_halt;
        bdm_active && !reg_wr |=> $stable(st_ff.cnt);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved in debug");

    property p_wrap;
        tick && !st_ff.center_pwm_select && st_ff.cnt == tc |=> st_ff.cnt == tmc_pkg::CNT_ZERO && st_ff.counter_overflow_flag;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap or overflow flag wrong");

    property p_reverse;
        tick && st_ff.center_pwm_select && !st_ff.down && st_ff.cnt == tc && !reg_wr
            |=> st_ff.down && st_ff.counter_overflow_flag && st_ff.cnt == $past(st_ff.cnt) - 16'h0001;
    endproperty
    a_reverse: assert property (p_reverse) else $error("direction change wrong");

    property p_irq;
        tof_irq == (st_ff.counter_overflow_flag && st_ff.overflow_interrupt_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("overflow request missing");

    property p_cnt_write;
        reg_wr && (reg_addr == tmc_pkg::ADDR_CNTH || reg_addr == tmc_pkg::ADDR_CNTL)
            |=> st_ff.cnt == tmc_pkg::CNT_ZERO && !st_ff.cnt_lat;
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("counter write did not clear");

endmodule

/* bench/tmc_pin_model.sv */
`timescale 1ns/1ps
module tmc_pin_model (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        ext_level,
    input  wire logic        count_en,
    input  wire logic        chan_pin_out,
    input  wire logic        chan_pin_oe,
    output logic             chan_pin_in,
    output logic             ext_clk_pin,
    output logic      [15:0] high_count
);
    logic [1:0] div_ff;

    // pin level: the block wins while it drives, else the outside source
    assign chan_pin_in = chan_pin_oe ? chan_pin_out : ext_level;

    // outside clock at an eighth of the bus rate, well under the quarter limit
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_ff <= 2'h0;
            ext_clk_pin <= 1'b0;
        end else begin
            div_ff <= div_ff + 2'h1;
            if (div_ff == 2'h3) begin
                ext_clk_pin <= !ext_clk_pin;
            end
        end
    end

    // high cycles seen on the pin while the window is open
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            high_count <= 16'h0000;
        end else if (!count_en) begin
            high_count <= 16'h0000;
        end else begin
            high_count <= high_count + 16'(chan_pin_out);
        end
    end
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        bdm_active = 1'b0;
    logic        stop_mode = 1'b0;
    logic        fixed_clk_tick = 1'b0;
    logic        ext_clk_pin, chan_pin_in, chan_pin_out, chan_pin_oe, tof_irq, chan_irq;
    logic        ext_level = 1'b0;
    logic        count_en = 1'b0;
    logic [15:0] high_count, v0, v1;
    logic [7:0]  rd_byte;
    int          failures = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [7:0]  pwm_csc [4] = '{8'h28, 8'h2c, 8'h2c, 8'h28};
    logic [7:0]  pwm_val [4] = '{8'h10, 8'h10, 8'h08, 8'h10};
    logic [15:0] pwm_exp [4] = '{16'h0010, 16'h0011, 16'h0019, 16'h0020};

    tmc_timer tmc_timer_inst (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .bdm_active, .stop_mode, .fixed_clk_tick, .ext_clk_pin, .chan_pin_in,
        .chan_pin_out, .chan_pin_oe, .tof_irq, .chan_irq);
    tmc_pin_model tmc_pin_model_inst (.clock, .arst_n, .ext_level, .count_en, .chan_pin_out,
        .chan_pin_oe, .chan_pin_in, .ext_clk_pin, .high_count);

    // ****************************************
    // clock, hang guard and bus tasks
    // ****************************************
    always #10 clock = ~clock;

    // a generous ceiling: the whole sequence needs about thirteen hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        rd_byte = reg_rdata;
    endtask

    task automatic rd_cnt(output logic [15:0] v);
        rd(tmc_pkg::ADDR_CNTL);
        v[7:0] = rd_byte;
        rd(tmc_pkg::ADDR_CNTH);
        v[15:8] = rd_byte;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        rd(tmc_pkg::ADDR_CVH);
        check("value_high", 16'h0000, rd_byte);
        rd(tmc_pkg::ADDR_CVL);
        check("value_low", 16'h0000, rd_byte);
        rd(tmc_pkg::ADDR_TSC);
        check("timer status", 16'h0000, rd_byte);
        wr(4'hc, 8'hff);
        rd(4'hc);
        check("unmapped", 16'h0000, rd_byte);
        settle(8);
        rd_cnt(v0);
        check("idle count", 16'h0000, v0);
        // up count to 5 with the overflow interrupt on
        wr(tmc_pkg::ADDR_MODH, 8'h00);
        wr(tmc_pkg::ADDR_MODL, 8'h05);
        wr(tmc_pkg::ADDR_TSC, 8'h48);
        settle(20);
        check("tof_irq", 16'h0001, tof_irq);
        rd(tmc_pkg::ADDR_CNTL);
        v0[7:0] = rd_byte;
        settle(7);
        rd(tmc_pkg::ADDR_CNTL);
        check("count snapshot", {8'h00, v0[7:0]}, {8'h00, rd_byte});
        rd(tmc_pkg::ADDR_CNTH);
        check("count range", 16'h0001, 16'(v0 <= 16'h0005 && rd_byte == 8'h00));
        // stop first so no fresh overflow races the clear
        wr(tmc_pkg::ADDR_TSC, 8'h40);
        rd(tmc_pkg::ADDR_TSC);
        check("tof", 16'h0001, rd_byte[7]);
        wr(tmc_pkg::ADDR_TSC, 8'h40);
        settle(3);
        check("tof_irq cleared", 16'h0000, tof_irq);
        wr(tmc_pkg::ADDR_TSC, 8'h08);
        for (int i = 0; i < 2; i++) begin
            @(posedge clock);
            bdm_active <= (i == 0);
            stop_mode <= (i == 1);
            rd_cnt(v0);
            settle(9);
            rd_cnt(v1);
            check("halted count", v0, v1);
        end
        @(posedge clock);
        bdm_active <= 1'b0;
        stop_mode <= 1'b0;
        wr(tmc_pkg::ADDR_TSC, 8'h00);
        rd(tmc_pkg::ADDR_CNTL);
        wr(tmc_pkg::ADDR_CNTH, 8'h5a);
        rd_cnt(v1);
        check("count after write", 16'h0000, v1);
        // up/down count to 3: no flag before the first reversal
        wr(tmc_pkg::ADDR_MODH, 8'h00);
        wr(tmc_pkg::ADDR_MODL, 8'h03);
        // the halt loop may have wrapped the counter: arm and clear a stale flag
        rd(tmc_pkg::ADDR_TSC);
        wr(tmc_pkg::ADDR_TSC, 8'h28);
        rd(tmc_pkg::ADDR_TSC);
        check("tof before reversal", 16'h0000, rd_byte[7]);
        settle(6);
        rd(tmc_pkg::ADDR_TSC);
        check("tof at reversal", 16'h0001, rd_byte[7]);
        // output compare at 0x10 in a 33 cycle period
        wr(tmc_pkg::ADDR_MODH, 8'h00);
        wr(tmc_pkg::ADDR_MODL, 8'h20);
        wr(tmc_pkg::ADDR_TSC, 8'h08);
        wr(tmc_pkg::ADDR_CSC, 8'h1c);
        wr(tmc_pkg::ADDR_CVH, 8'h00);
        wr(tmc_pkg::ADDR_CVL, 8'h10);
        for (int e = 3; e >= 1; e--) begin
            wr(tmc_pkg::ADDR_CSC, 8'h10 | 8'(e << 2));
            settle(40);
            v0[0] = chan_pin_out;
            settle(33);
            check("compare pin", (e == 1) ? 16'(!v0[0]) : 16'(e == 3), chan_pin_out);
            check("compare enable", 16'h0001, chan_pin_oe);
        end
        wr(tmc_pkg::ADDR_CSC, 8'h50);
        settle(40);
        check("released pin", 16'h0000, chan_pin_oe);
        check("match irq", 16'h0001, chan_irq);
        wr(tmc_pkg::ADDR_CSC, 8'h1c);
        settle(40);
        wr(tmc_pkg::ADDR_CVL, 8'h30);
        wr(tmc_pkg::ADDR_CSC, 8'h18);
        wr(tmc_pkg::ADDR_CVH, 8'h00);
        settle(80);
        check("half write dropped", 16'h0000, chan_pin_out);
        // edge pwm: high cycles over exactly one period
        // the last pass runs center pwm, whose period is 64 cycles
        for (int k = 0; k < 4; k++) begin
            if (k == 3) begin
                wr(tmc_pkg::ADDR_TSC, 8'h28);
            end
            wr(tmc_pkg::ADDR_CSC, pwm_csc[k]);
            wr(tmc_pkg::ADDR_CVH, 8'h00);
            wr(tmc_pkg::ADDR_CVL, pwm_val[k]);
            settle(70);
            @(posedge clock);
            count_en <= 1'b1;
            repeat ((k == 3) ? 64 : 33) @(posedge clock);
            count_en <= 1'b0;
            #1;
            check("pwm high cycles", pwm_exp[k], high_count);
        end
        wr(tmc_pkg::ADDR_TSC, 8'h08);
        // capture: pin left quiet before each reconfiguration
        wr(tmc_pkg::ADDR_CSC, 8'h00);
        settle(5);
        for (int e = 1; e <= 3; e++) begin
            for (int p = 1; p >= 0; p--) begin
                rd(tmc_pkg::ADDR_CSC);
                wr(tmc_pkg::ADDR_CSC, 8'h40 | 8'(e << 2));
                settle(3);
                ext_level <= p[0];
                settle(10);
                check("capture irq", 16'((p == 1) ? (e != 2) : (e != 1)), chan_irq);
            end
        end
        rd(tmc_pkg::ADDR_CVL);
        v0[7:0] = rd_byte;
        ext_level <= 1'b1;
        settle(13);
        rd(tmc_pkg::ADDR_CVL);
        check("capture frozen", {8'h00, v0[7:0]}, {8'h00, rd_byte});
        wr(tmc_pkg::ADDR_TSC, 8'h18);
        wr(tmc_pkg::ADDR_CNTL, 8'h00);
        settle(80);
        wr(tmc_pkg::ADDR_TSC, 8'h00);
        rd_cnt(v0);
        check("outside clock count", 16'h0001, 16'(v0 >= 16'h0008 && v0 <= 16'h000b));
        report_and_stop();
    end
endmodule
